// [wsr_pkg.sv]
// Purpose : shared constants for the wide odd-byte residue block
// Assumes : 16-bit wide bus, byte-wide memory stream
// Notes   : all widths and counts are fixed here
`default_nettype none

package wsr_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned COUNT_W = 24;   // move byte count width

  // ----------------------------------------------------------------
  // fifo shape and reset values
  // ----------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [BYTE_W-1:0]  BYTE_RST  = 8'h00;
  localparam logic [WORD_W-1:0]  WORD_RST  = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 24'h000001;
  localparam logic [COUNT_W-1:0] COUNT_RST = 24'h000000;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_S_LO,
    ST_S_HI,
    ST_S_TX,
    ST_R_RES,
    ST_R_RX,
    ST_R_LO,
    ST_R_HI,
    ST_DONE
  } wsr_state_t;

endpackage

`default_nettype wire

// [wsr_fifo.sv]
// Purpose : byte fifo between the residue logic and memory writes
// Assumes : single clock, synchronous active-low reset
// Notes   : flip-flop storage, full and empty are exact
`default_nettype none

module wsr_fifo
  import wsr_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
)
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // handshake decode
  // ----------------------------------------------------------------
  assign push       = in_valid && in_ready;
  assign pop        = out_valid && out_ready;
  assign in_ready   = (count_reg != (AW+1)'(DEPTH));
  assign out_valid  = (count_reg != '0);
  assign out_data   = mem_reg[rd_ptr_reg];
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

  // pointers wrap naturally because depth is a power of two
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      count_reg <= count_next;
    end
  end

  // storage is not reset; empty fifo never exposes it as valid
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data;
  end

endmodule

`default_nettype wire

// [wsr_residue.sv]
// Purpose : odd-byte residue handling for wide bus block moves
// Assumes : one move at a time, inputs synchronous to sys_clk
// Notes   : memory bytes go low byte first; writes pass a fifo
`default_nettype none

module wsr_residue
  import wsr_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               move_start,
  input  wire logic               move_send,
  input  wire logic               move_chained,
  input  wire logic [COUNT_W-1:0] move_count,
  input  wire logic               clr_send_flag,
  input  wire logic               clr_recv_flag,
  input  wire logic [BYTE_W-1:0]  mem_rd_data,
  input  wire logic               mem_rd_valid,
  output logic                    mem_rd_ready,
  output logic      [BYTE_W-1:0]  mem_wr_data,
  output logic                    mem_wr_valid,
  input  wire logic               mem_wr_ready,
  output logic      [WORD_W-1:0]  scsi_tx_word,
  output logic                    scsi_tx_odd,
  output logic                    scsi_tx_valid,
  input  wire logic               scsi_tx_ready,
  input  wire logic [WORD_W-1:0]  scsi_rx_word,
  input  wire logic               scsi_rx_valid,
  output logic                    scsi_rx_ready,
  output logic                    send_residue_flag,
  output logic                    receive_residue_flag,
  output logic      [BYTE_W-1:0]  output_data_latch,
  output logic      [BYTE_W-1:0]  wide_residue_register,
  output logic                    move_busy,
  output logic                    move_done
);

  // ----------------------------------------------------------------
  // state and datapath registers
  // ----------------------------------------------------------------
  wsr_state_t         state_reg;
  wsr_state_t         state_next;
  logic [COUNT_W-1:0] cnt_reg;
  logic               chained_reg;
  logic               marry_reg;
  logic [BYTE_W-1:0]  lo_byte_reg;
  logic [WORD_W-1:0]  rx_word_reg;
  logic               wss_reg;
  logic               wsr_reg;
  logic [BYTE_W-1:0]  odl_reg;
  logic [BYTE_W-1:0]  wide_residue_register_reg;
  logic [WORD_W-1:0]  tx_word_reg;
  logic               tx_odd_reg;
  logic               tx_valid_reg;
  logic               rd_ready_reg;
  logic               rx_ready_reg;
  logic               busy_reg;
  logic               done_reg;

  // last-byte test is shared by the send and receive paths
  function automatic logic fn_last(input logic [COUNT_W-1:0] c);
    fn_last = (c == COUNT_ONE);
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic              start_ok;
  logic              rd_take;
  logic              tx_take;
  logic              rx_take;
  logic              push_valid;
  logic              push_ready;
  logic              push_take;
  logic [BYTE_W-1:0] push_data;
  logic              cnt_last;
  logic              send_part;
  logic              wss_set;
  logic              wss_hw_clr;
  logic              wsr_set;
  logic              wsr_start_clr;
  logic              res_first;

  assign start_ok   = (state_reg == ST_IDLE) && move_start;
  assign rd_take    = rd_ready_reg && mem_rd_valid;
  assign tx_take    = tx_valid_reg && scsi_tx_ready;
  assign rx_take    = rx_ready_reg && scsi_rx_valid;
  assign push_take  = push_valid && push_ready;
  assign cnt_last   = fn_last(cnt_reg);
  assign push_valid = (state_reg == ST_R_RES) || (state_reg == ST_R_LO)
                      || (state_reg == ST_R_HI);
  // residue byte leads, then low and high halves of each bus word
  assign push_data  = (state_reg == ST_R_RES) ? wide_residue_register_reg
                    : (state_reg == ST_R_LO)  ? rx_word_reg[7:0]
                    : rx_word_reg[15:8];
  // a final lone low byte in a chained send stays behind
  assign send_part  = (state_reg == ST_S_LO) && rd_take && cnt_last;
  assign wss_set    = send_part && chained_reg;
  assign wss_hw_clr = tx_take && marry_reg;
  assign wsr_set    = (state_reg == ST_R_LO) && push_take
                      && cnt_last;
  assign wsr_start_clr = start_ok && !move_send;
  assign res_first  = move_chained && wsr_reg;

  // ----------------------------------------------------------------
  // next state; count drops per memory byte only
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (move_start)
        begin
          if (move_count == COUNT_RST)
            state_next = ST_DONE;
          else if (move_send)
            state_next = wss_reg ? ST_S_HI : ST_S_LO;
          else
            state_next = res_first ? ST_R_RES : ST_R_RX;
        end
      ST_S_LO:
        if (rd_take)
        begin
          if (cnt_last && chained_reg)
            state_next = ST_DONE;
          else if (cnt_last)
            state_next = ST_S_TX;
          else
            state_next = ST_S_HI;
        end
      ST_S_HI:
        if (rd_take)
          state_next = ST_S_TX;
      ST_S_TX:
        if (tx_take)
          state_next = (cnt_reg == COUNT_RST) ? ST_DONE : ST_S_LO;
      ST_R_RES:
        if (push_take)
          state_next = cnt_last ? ST_DONE : ST_R_RX;
      ST_R_RX:
        if (rx_take)
          state_next = ST_R_LO;
      ST_R_LO:
        if (push_take)
          state_next = cnt_last ? ST_DONE : ST_R_HI;
      ST_R_HI:
        if (push_take)
          state_next = cnt_last ? ST_DONE : ST_R_RX;
      ST_DONE:
        state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencing registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= COUNT_RST;
      chained_reg <= 1'b0;
      marry_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (start_ok)
      begin
        cnt_reg     <= move_count;
        chained_reg <= move_chained;
        marry_reg   <= move_send && wss_reg;
      end
      else if (rd_take || push_take)
        cnt_reg <= cnt_reg - COUNT_ONE;
      if (tx_take)
        marry_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // byte capture and bus word build
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      lo_byte_reg <= BYTE_RST;
      rx_word_reg <= WORD_RST;
      tx_word_reg <= WORD_RST;
      tx_odd_reg  <= 1'b0;
    end
    else
    begin
      if (start_ok && move_send)
        lo_byte_reg <= odl_reg;
      else if ((state_reg == ST_S_LO) && rd_take)
        lo_byte_reg <= mem_rd_data;
      if (rx_take)
        rx_word_reg <= scsi_rx_word;
      if ((state_reg == ST_S_HI) && rd_take)
      begin
        tx_word_reg <= {mem_rd_data, lo_byte_reg};
        tx_odd_reg  <= 1'b0;
      end
      else if (send_part && !chained_reg)
      begin
        // normal move: lone last byte goes out on its own
        tx_word_reg <= {BYTE_RST, mem_rd_data};
        tx_odd_reg  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // residue flags and holding registers; hardware set wins
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wss_reg   <= 1'b0;
      wsr_reg   <= 1'b0;
      odl_reg   <= BYTE_RST;
      wide_residue_register_reg <= BYTE_RST;
    end
    else
    begin
      wss_reg <= wss_set
                 || (wss_reg && !wss_hw_clr && !clr_send_flag);
      wsr_reg <= wsr_set
                 || (wsr_reg && !wsr_start_clr && !clr_recv_flag);
      if (wss_set)
        odl_reg <= mem_rd_data;
      if (wsr_set)
        wide_residue_register_reg <= rx_word_reg[15:8];
    end
  end

  // ----------------------------------------------------------------
  // registered handshakes follow the next state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      tx_valid_reg <= 1'b0;
      rd_ready_reg <= 1'b0;
      rx_ready_reg <= 1'b0;
      busy_reg     <= 1'b0;
      done_reg     <= 1'b0;
    end
    else
    begin
      tx_valid_reg <= (state_next == ST_S_TX);
      rd_ready_reg <= (state_next == ST_S_LO) || (state_next == ST_S_HI);
      rx_ready_reg <= (state_next == ST_R_RX);
      busy_reg     <= (state_next != ST_IDLE);
      done_reg     <= (state_next == ST_DONE);
    end
  end

  // memory writes may stall; that back-pressure halts the receive walk
  wsr_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_data   (push_data),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .out_data  (mem_wr_data),
    .out_valid (mem_wr_valid),
    .out_ready (mem_wr_ready)
  );

  assign mem_rd_ready          = rd_ready_reg;
  assign scsi_tx_word          = tx_word_reg;
  assign scsi_tx_odd           = tx_odd_reg;
  assign scsi_tx_valid         = tx_valid_reg;
  assign scsi_rx_ready         = rx_ready_reg;
  assign send_residue_flag     = wss_reg;
  assign receive_residue_flag  = wsr_reg;
  assign output_data_latch     = odl_reg;
  assign wide_residue_register = wide_residue_register_reg;
  assign move_busy             = busy_reg;
  assign move_done             = done_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_WSS_ONLY_CHAINED: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(wss_reg) |-> $past(chained_reg) && $past(state_reg) == ST_S_LO)
    else $error("send flag set outside a chained send");

  AST_PARTIAL_HELD: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (send_part && chained_reg) |=> odl_reg == $past(mem_rd_data)
      && !tx_valid_reg && state_reg == ST_DONE)
    else $error("partial send byte not held in latch");

  AST_MARRY_LOW: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (start_ok && move_send && wss_reg && move_count != COUNT_RST)
      |=> state_reg == ST_S_HI && lo_byte_reg == $past(odl_reg))
    else $error("married word does not use held low byte");

  AST_WSS_AUTO_CLR: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (tx_take && marry_reg && !wss_set) |=> !wss_reg)
    else $error("send flag not cleared after married word");

  AST_SW_CLR: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clr_recv_flag && !wsr_set) ##1 1'b1 |-> !wsr_reg)
    else $error("software clear of receive flag lost");

  AST_SW_CLR_SEND: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clr_send_flag && !wss_set) |=> !wss_reg)
    else $error("software clear of send flag lost");

  AST_WSR_SET: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wsr_set |=> wsr_reg && wide_residue_register_reg == $past(rx_word_reg[15:8])
      ##1 state_reg == ST_IDLE)
    else $error("partial receive did not hold high byte");

  AST_WSR_START_CLR: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (start_ok && !move_send) |=> !wsr_reg)
    else $error("receive flag not cleared at receive start");

  AST_RES_ORDER: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (start_ok && !move_send && move_count != COUNT_RST)
      |=> (state_reg == ST_R_RES) == $past(move_chained && wsr_reg))
    else $error("residue byte order wrong for move type");

  AST_COUNT_BOUND: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (rd_take || push_take) |-> cnt_reg != COUNT_RST)
    else $error("memory byte moved beyond byte count");

endmodule

`default_nettype wire

// [wsr_bus_model.sv]
// Purpose : far side of the wide bus, takes sent words, offers receive words
// Assumes : bench fills rx_q and reads tx_q; outputs change on falling edge
// Notes   : slow mode halves the handshake rate to stretch every transfer
`default_nettype none

module wsr_bus_model
(
  input  wire logic        sys_clk,
  input  wire logic        slow,
  input  wire logic [15:0] scsi_tx_word,
  input  wire logic        scsi_tx_odd,
  input  wire logic        scsi_tx_valid,
  output logic             scsi_tx_ready,
  output logic      [15:0] scsi_rx_word,
  output logic             scsi_rx_valid,
  input  wire logic        scsi_rx_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [16:0] tx_q [$];
  logic [15:0] rx_q [$];
  logic        phase = 1'b0;
  logic        took  = 1'b0;
  logic [15:0] last  = 16'h0000;

  initial
  begin
    scsi_tx_ready = 1'b0;
    scsi_rx_valid = 1'b0;
    scsi_rx_word  = 16'hffff;
  end

  // ----------------------------------------------------------------
  // drive side: a pending word is held until taken, else junk shows
  // ----------------------------------------------------------------
  always @(negedge sys_clk)
  begin
    phase = ~phase;
    scsi_tx_ready = !slow || phase;
    if (scsi_rx_valid && !took)
      scsi_rx_valid = 1'b1;
    else if (rx_q.size() > 0 && (!slow || phase))
    begin
      scsi_rx_valid = 1'b1;
      scsi_rx_word  = rx_q[0];
    end
    else
    begin
      scsi_rx_valid = 1'b0;
      scsi_rx_word  = ~last;   // released bus never repeats old data
    end
  end

  // capture on the edge where both sides agree
  always @(posedge sys_clk)
  begin
    took = scsi_rx_valid && scsi_rx_ready;
    if (took)
      last = rx_q.pop_front();
    if (scsi_tx_valid && scsi_tx_ready)
      tx_q.push_back({scsi_tx_odd, scsi_tx_word});
  end
endmodule

`default_nettype wire

// [test_wide_scsi_odd_byte_residue.sv]
// Purpose : self-checking bench for the wide odd-byte residue block
// Assumes : memory source and sink are modelled here, bus side by model
// Notes   : moves run one at a time; expectations are fixed word and byte lists
`default_nettype none

module test_wide_scsi_odd_byte_residue
  import wsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0, rst_n = 1'b0, slow = 1'b0, wr_stall = 1'b0;
  logic move_start = 1'b0, move_send = 1'b0, move_chained = 1'b0;
  logic [COUNT_W-1:0] move_count = COUNT_RST;
  logic clr_send_flag = 1'b0, clr_recv_flag = 1'b0;
  logic [BYTE_W-1:0] mem_rd_data = 8'h00, mem_wr_data;
  logic mem_rd_valid = 1'b0, mem_rd_ready, mem_wr_valid, mem_wr_ready = 1'b0;
  logic [WORD_W-1:0] scsi_tx_word, scsi_rx_word;
  logic scsi_tx_odd, scsi_tx_valid, scsi_tx_ready, scsi_rx_valid, scsi_rx_ready;
  logic send_residue_flag, receive_residue_flag, move_busy, move_done;
  logic [BYTE_W-1:0] output_data_latch, wide_residue_register;
  logic [7:0] rd_q [$];
  logic [7:0] wr_q [$];
  int fails = 0, num_checks = 0;

  always #4 sys_clk = ~sys_clk;

  wsr_residue dut (.sys_clk(sys_clk), .rst_n(rst_n), .move_start(move_start),
    .move_send(move_send), .move_chained(move_chained),
    .move_count(move_count), .clr_send_flag(clr_send_flag),
    .clr_recv_flag(clr_recv_flag), .mem_rd_data(mem_rd_data),
    .mem_rd_valid(mem_rd_valid), .mem_rd_ready(mem_rd_ready),
    .mem_wr_data(mem_wr_data), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .scsi_tx_word(scsi_tx_word),
    .scsi_tx_odd(scsi_tx_odd), .scsi_tx_valid(scsi_tx_valid),
    .scsi_tx_ready(scsi_tx_ready), .scsi_rx_word(scsi_rx_word),
    .scsi_rx_valid(scsi_rx_valid), .scsi_rx_ready(scsi_rx_ready),
    .send_residue_flag(send_residue_flag),
    .receive_residue_flag(receive_residue_flag),
    .output_data_latch(output_data_latch),
    .wide_residue_register(wide_residue_register),
    .move_busy(move_busy), .move_done(move_done));

  wsr_bus_model bus (.sys_clk(sys_clk), .slow(slow),
    .scsi_tx_word(scsi_tx_word), .scsi_tx_odd(scsi_tx_odd),
    .scsi_tx_valid(scsi_tx_valid), .scsi_tx_ready(scsi_tx_ready),
    .scsi_rx_word(scsi_rx_word), .scsi_rx_valid(scsi_rx_valid),
    .scsi_rx_ready(scsi_rx_ready));

  // ----------------------------------------------------------------
  // memory source holds each byte until taken; sink may stall
  // ----------------------------------------------------------------
  always @(negedge sys_clk)
  begin
    mem_rd_valid = rd_q.size() > 0;
    mem_rd_data  = mem_rd_valid ? rd_q[0] : ~mem_rd_data;
    mem_wr_ready = !wr_stall;
  end

  always @(posedge sys_clk)
  begin
    if (mem_rd_valid && mem_rd_ready)
      void'(rd_q.pop_front());
    if (mem_wr_valid === 1'b1 && mem_wr_ready)
      wr_q.push_back(mem_wr_data);
  end

  // ----------------------------------------------------------------
  // compare and closing tasks
  // ----------------------------------------------------------------
  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_w(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task complete_run;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one move, waits a bounded time for the done pulse
  task automatic do_move(input logic s, input logic ch, input int n);
    int i;
    move_send = s;
    move_chained = ch;
    move_count = COUNT_W'(n);
    move_start = 1'b1;
    @(negedge sys_clk);
    move_start = 1'b0;
    for (i = 0; i < 600 && move_done !== 1'b1; i++)
      @(negedge sys_clk);
    if (move_done !== 1'b1)
    begin
      fails++;
      complete_run();
    end
    @(negedge sys_clk);
  endtask

  // words seen on the bus, then bytes seen by memory, then nothing more
  task automatic bus_is(input logic [16:0] e [$]);
    foreach (e[i])
      chk_w(bus.tx_q.size() > 0 ? bus.tx_q.pop_front() : 17'h1ffff, e[i]);
    chk_w(17'(bus.tx_q.size()), 17'h00000);
  endtask

  task automatic mem_is(input logic [7:0] e [$]);
    foreach (e[i])
      chk_b(wr_q.size() > 0 ? wr_q.pop_front() : 8'hxx, e[i]);
    chk_b(8'(wr_q.size()), 8'h00);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic send_runs;
    rd_q = '{8'h11, 8'h22, 8'h33};
    do_move(1'b1, 1'b1, 3);
    bus_is('{17'h02211});
    chk_b(output_data_latch, 8'h33);
    chk_b(8'(send_residue_flag), 8'h01);
    slow = 1'b1;
    rd_q = '{8'h44, 8'h55, 8'h66};
    do_move(1'b1, 1'b0, 3);
    bus_is('{17'h04433, 17'h06655});
    chk_b(8'(send_residue_flag), 8'h00);
    slow = 1'b0;
    rd_q = '{8'h77};
    do_move(1'b1, 1'b0, 1);
    bus_is('{17'h10077});
    chk_b(8'(send_residue_flag), 8'h00);
  endtask

  task automatic send_clear;
    rd_q = '{8'h88};
    do_move(1'b1, 1'b1, 1);
    chk_w(17'(bus.tx_q.size()), 17'h00000);
    chk_b(output_data_latch, 8'h88);
    chk_b(8'(send_residue_flag), 8'h01);
    clr_send_flag = 1'b1;
    @(negedge sys_clk);
    clr_send_flag = 1'b0;
    @(negedge sys_clk);
    chk_b(8'(send_residue_flag), 8'h00);
  endtask

  task automatic recv_runs;
    bus.rx_q = '{16'hb2a1, 16'hd4c3};
    do_move(1'b0, 1'b0, 3);
    mem_is('{8'ha1, 8'hb2, 8'hc3});
    chk_b(wide_residue_register, 8'hd4);
    chk_b(8'(receive_residue_flag), 8'h01);
    slow = 1'b1;
    bus.rx_q = '{16'hf6e5};
    do_move(1'b0, 1'b1, 3);
    mem_is('{8'hd4, 8'he5, 8'hf6});
    chk_b(8'(receive_residue_flag), 8'h00);
    slow = 1'b0;
  endtask

  task automatic recv_ignore;
    bus.rx_q = '{16'h2019};
    do_move(1'b0, 1'b0, 1);
    chk_b(8'(receive_residue_flag), 8'h01);
    bus.rx_q = '{16'h3231};
    do_move(1'b0, 1'b0, 2);
    mem_is('{8'h19, 8'h31, 8'h32});
    chk_b(8'(receive_residue_flag), 8'h00);
    bus.rx_q = '{16'h4241, 16'h5453};
    do_move(1'b0, 1'b1, 3);
    mem_is('{8'h41, 8'h42, 8'h53});
    chk_b(8'(receive_residue_flag), 8'h01);
    clr_recv_flag = 1'b1;
    @(negedge sys_clk);
    clr_recv_flag = 1'b0;
    @(negedge sys_clk);
    chk_b(8'(receive_residue_flag), 8'h00);
  endtask

  // sink stalls so the fifo fills and the bus side is held off
  task automatic recv_stall;
    logic [7:0] e [$];
    int i;
    wr_stall = 1'b1;
    for (i = 0; i < 16; i++)
    begin
      bus.rx_q.push_back({8'(2 * i + 1), 8'(2 * i)});
      e.push_back(8'(2 * i));
      e.push_back(8'(2 * i + 1));
    end
    move_send = 1'b0;
    move_chained = 1'b0;
    move_count = COUNT_W'(32);
    move_start = 1'b1;
    @(negedge sys_clk);
    move_start = 1'b0;
    repeat (60) @(negedge sys_clk);
    chk_b(8'(wr_q.size()), 8'h00);
    chk_b(8'(mem_wr_valid), 8'h01);
    chk_b(8'(bus.rx_q.size() > 0), 8'h01);
    wr_stall = 1'b0;
    // the fifo drains slower than the walk ends, so wait for it too
    for (i = 0; i < 600
         && (move_busy !== 1'b0 || mem_wr_valid !== 1'b0); i++)
      @(negedge sys_clk);
    if (move_busy !== 1'b0 || mem_wr_valid !== 1'b0)
    begin
      fails++;
      complete_run();
    end
    repeat (4) @(negedge sys_clk);
    mem_is(e);
  endtask

  initial
  begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    send_runs();
    send_clear();
    recv_runs();
    recv_ignore();
    recv_stall();
    complete_run();
  end
endmodule

`default_nettype wire
